/* File: dv/adst_far_model.sv */
// far-side model: timer match lines, capture/match pins, analog sample
`timescale 1ns/1ps
`default_nettype none
module adst_far_model (
	input wire logic aclk, // clock
	output logic [1:0] trig_pin, // capture/match pins
	output logic [3:0] trig_match, // timer match lines
	output logic [9:0] conv_value // analog core sample
);
	logic [5:0] src_q = 6'h00;
	logic [9:0] smp_q = 10'h000;
	// four match lines and two pins, levels changed after an edge
	assign trig_pin = src_q[1:0];
	assign trig_match = src_q[5:2];
	assign conv_value = smp_q;
	task automatic set_src(input logic [5:0] v);
		@(posedge aclk);
		src_q <= v;
	endtask
	task automatic set_smp(input logic [9:0] v);
		@(posedge aclk);
		smp_q <= v;
	endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the converter status and trigger logic
`timescale 1ns/1ps
`default_nettype none
`include "adst_params.svh"
module testbench;
	localparam logic [7:0] CT = `ADST_OFF_CTRL;
	localparam logic [7:0] ST = `ADST_OFF_STATUS;
	localparam logic [7:0] TR = `ADST_OFF_TRIM;
	localparam logic [7:0] IE = `ADST_OFF_IRQEN;
	localparam logic [7:0] IS = `ADST_OFF_IRQST;
	localparam logic [7:0] IM = `ADST_OFF_IRQMSK;
	localparam logic [7:0] R0 = `ADST_OFF_RESULT0;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	// response readies stay high; the slave's valid is its answer
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
	logic arvalid = 1'b0, rready = 1'b1, busy_d = 1'b0;
	logic ce = 1'b1;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] wdata = 32'h0;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic cbusy, cirq, dreq, irq;
	wire logic [1:0] bresp, rresp, tpin;
	wire logic [3:0] tmat, trim;
	wire logic [9:0] cval;
	wire logic [2:0] chan;
	wire logic [31:0] rdata;
	int num_errors = 0, samples_checked = 0, starts = 0, s;
	logic [5:0] idle, sl, un;

	always #20 aclk = ~aclk;
	// counts conversion starts seen at the busy output
	always @(posedge aclk) begin
		busy_d <= cbusy;
		if (cbusy === 1'b1 && busy_d !== 1'b1)
			starts++;
	end

	adst_far_model far_u (.aclk(aclk), .trig_pin(tpin), .trig_match(tmat),
		.conv_value(cval));
	adst_top #(.CONV_CYC(16)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .trig_pin(tpin), .trig_match(tmat),
		.conv_value(cval), .offset_trim_value(trim), .conv_busy(cbusy),
		.conv_chan(chan), .converter_irq(cirq), .dma_req(dreq), .irq(irq));

	//==========================================================
	// reporting
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic hang(input string m);
		num_errors++;
		$display("[FAIL] %0t %s", $time, m);
		conclude();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask

	//==========================================================
	// bus cycles, entered just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = 2'b00);
		int n;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		if (n == 64)
			hang("write hang");
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = 2'b00);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		if (n == 64)
			hang("read hang");
		chk({30'h0, rresp}, {30'h0, er});
		if (er === 2'b00)
			chk(rdata, e);
	endtask
	task automatic wait_starts(input int t);
		int n;
		for (n = 0; n < 400 && starts < t; n++)
			@(posedge aclk);
		if (n == 400)
			hang("no start");
	endtask
	task automatic wait_idle;
		int n;
		for (n = 0; n < 100 && cbusy !== 1'b0; n++)
			@(posedge aclk);
		if (n == 100)
			hang("conversion hang");
		// done lands in the same cycle that busy drops
		repeat (2) @(posedge aclk);
	endtask

	//==========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ST, 32'h0);
		rd(TR, 32'h0);
		rd(IE, 32'h000000ff);
		rd(8'hfc, 32'h0, 2'b10);
		wr(8'hfc, 32'h0, 2'b10);
		wr(TR, 32'hffffffff);
		rd(TR, 32'h000000f0);
		chk({28'h0, trim}, 32'h0000000f);
		// a write without the low byte strobe leaves the trim alone
		wstrb <= 4'he;
		wr(TR, 32'h0);
		wstrb <= 4'hf;
		rd(TR, 32'h000000f0);
		$display("reset and trim test done");

		far_u.set_smp(10'h2a5);
		s = starts;
		wr(CT, 32'h01000001);
		// restarts by software and by a pin edge while busy are dropped
		wr(CT, 32'h01000001);
		wr(CT, 32'h02000001);
		far_u.set_src(6'h01);
		wait_starts(s + 1);
		wait_idle();
		repeat (8) @(posedge aclk);
		chk(32'(starts), 32'(s + 1));
		chk({30'h0, cirq, dreq}, 32'h3);
		rd(ST, 32'h00010001);
		wr(ST, 32'h0);
		rd(ST, 32'h00010001);
		chk({31'h0, irq}, 32'h0);
		wr(IM, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rd(IS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		rd(IS, 32'h0);
		wr(IE, 32'h0);
		chk({30'h0, cirq, dreq}, 32'h0);
		rd(ST, 32'h00000001);
		wr(IE, 32'hff);
		rd(R0, 32'h8000a940);
		chk({30'h0, cirq, dreq}, 32'h0);
		rd(ST, 32'h0);
		$display("software start test done");

		for (int p = 0; p < 2; p++) begin
			for (int c = 2; c < 8; c++) begin
				idle = (p == 1) ? 6'h3f : 6'h00;
				sl = 6'h01 << (c - 2);
				un = 6'h01 << ((c - 1) % 6);
				wr(CT, 32'h0);
				far_u.set_src(idle);
				wr(CT, {4'h0, p[0], c[2:0], 23'h0, 1'b1});
				s = starts;
				far_u.set_src(idle ^ un);
				repeat (8) @(posedge aclk);
				chk(32'(starts), 32'(s));
				far_u.set_src(idle ^ un ^ sl);
				wait_starts(s + 1);
				wait_idle();
				chk(32'(starts), 32'(s + 1));
				rd(R0, 32'h8000a940);
			end
		end
		$display("trigger test done");

		// clock enable low freezes a running conversion
		wr(CT, 32'h01000001);
		ce <= 1'b0;
		repeat (24) @(posedge aclk);
		chk({31'h0, cbusy}, 32'h1);
		ce <= 1'b1;
		wait_idle();
		rd(R0, 32'h8000a940);
		$display("clock enable test done");

		wr(CT, 32'h0);
		far_u.set_src(6'h00);
		s = starts;
		wr(CT, 32'h00010001);
		wait_starts(s + 3);
		wr(CT, 32'h0);
		wait_idle();
		rd(ST, 32'h00010101);
		rd(R0, 32'hc000a940);
		rd(ST, 32'h0);
		$display("burst test done");

		// start with channels 0 and 2 enabled goes to the next one, 2
		wr(CT, 32'h01000005);
		chk({29'h0, chan}, 32'h2);
		wait_idle();
		rd(ST, 32'h00010004);
		rd(R0 + 8'h08, 32'h8000a940);
		rd(ST, 32'h0);
		$display("channel select test done");
		conclude();
	end
endmodule
`default_nettype wire

/* File: logic/adst_edge.sv */
// trigger source select and polarity-aware edge detector
`timescale 1ns/1ps
`default_nettype none
`include "adst_params.svh"
module adst_edge
	import adst_pkg::*;
(
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, active low
	input wire logic ce, // clock enable
	input wire logic [2:0] start_sel, // start field
	input wire logic edge_pol, // polarity select bit
	input wire logic [1:0] trig_pin, // capture/match pins
	input wire logic [3:0] trig_match, // timer match signals
	output logic trig_pulse // one cycle per qualifying edge
);
	typedef struct packed {
		logic prev;
		logic armed;
	} adst_edge_st_t;
	adst_edge_st_t s_q, s_d;
	logic src;
	always_comb begin
		case (adst_start_t'(start_sel))
		ADST_ST_PIN0: src = trig_pin[0];
		ADST_ST_PIN1: src = trig_pin[1];
		ADST_ST_MAT0: src = trig_match[0];
		ADST_ST_MAT1: src = trig_match[1];
		ADST_ST_MAT2: src = trig_match[2];
		ADST_ST_MAT3: src = trig_match[3];
		default: src = 1'b0;
		endcase
	end
	always_comb begin
		s_d = s_q;
		// xor with polarity, rising edge of result fires
		s_d.prev = src ^ edge_pol;
		s_d.armed = (start_sel >= 3'h2);
	end
	// armed gate avoids a false edge right after a change from start field 000/001 to a trigger source
	assign trig_pulse = s_q.armed && (start_sel >= 3'h2) && !s_q.prev
		&& (src ^ edge_pol);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end
	a_edge_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && trig_pulse |=> !trig_pulse)
		else $error("trigger pulse longer than one cycle");
endmodule
`default_nettype wire

/* File: logic/adst_params.svh */
// register offsets, field positions, reset values and timing counts
`ifndef ADST_PARAMS_SVH
`define ADST_PARAMS_SVH
`define ADST_OFF_CTRL 8'h00
`define ADST_OFF_STATUS 8'h04
`define ADST_OFF_TRIM 8'h08
`define ADST_OFF_IRQEN 8'h0c
`define ADST_OFF_IRQST 8'h10
`define ADST_OFF_IRQMSK 8'h14
`define ADST_OFF_RESULT0 8'h20
`define ADST_CTRL_SEL_LSB 0
`define ADST_CTRL_BURST 16
`define ADST_CTRL_START_LSB 24
`define ADST_CTRL_EDGE 27
`define ADST_STAT_IRQ_BIT 16
`define ADST_TRIM_LSB 4
`define ADST_CTRL_RST 32'h0000_0000
`define ADST_TRIM_RST 4'h0
`define ADST_IRQEN_RST 8'hff
`define ADST_CONV_NS 1760
`define ADST_CLK_NS 40
`define ADST_CONV_CYC ((`ADST_CONV_NS + `ADST_CLK_NS - 1) / `ADST_CLK_NS)
`define ADST_RES_LSB 6
`define ADST_RES_OVR 30
`define ADST_RES_DONE 31
`endif

/* File: logic/adst_pkg.sv */
// types shared by the converter status, trigger and request logic
package adst_pkg;
	typedef enum logic [1:0] {
		ADST_IDLE = 2'b00,
		ADST_CONV = 2'b01
	} adst_conv_t;
	typedef enum logic [2:0] {
		ADST_ST_NONE = 3'b000,
		ADST_ST_NOW = 3'b001,
		ADST_ST_PIN0 = 3'b010,
		ADST_ST_PIN1 = 3'b011,
		ADST_ST_MAT0 = 3'b100,
		ADST_ST_MAT1 = 3'b101,
		ADST_ST_MAT2 = 3'b110,
		ADST_ST_MAT3 = 3'b111
	} adst_start_t;
endpackage

/* File: logic/adst_top.sv */
// converter status, trigger, interrupt and dma request logic with axi slave
//==============================================================
// Function
// - status 7:0 mirror per-channel done flags
// - status 15:8 mirror per-channel overrun flags
// - status 16 is or of enabled done
// - status 31:17 zero, reset clears all
// - trim field 7:4, rw, resets zero
// - running conversion always finishes
// - starts during conversion are dropped, unqueued
// - burst off, start 010-111 uses trigger edge
// - triggers: four matches, two pins
// - edge detect on source xor bit 27
// - interrupt line high while an enabled done set
// - result read clears done and request
// - dma request equals interrupt request
// - done set when channel conversion ends
// - burst overwrite sets overrun, read clears
`timescale 1ns/1ps
`default_nettype none
`include "adst_params.svh"
module adst_top
	import adst_pkg::*;
#(
	parameter int NCH = 8,
	parameter int RES_W = 10,
	parameter int CONV_CYC = `ADST_CONV_CYC
) (
	input wire logic aclk, // clock, 25 mhz
	input wire logic aresetn, // sync reset, active low
	input wire logic ce, // clock enable
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [1:0] trig_pin, // capture/match pins
	input wire logic [3:0] trig_match, // timer match signals
	input wire logic [RES_W-1:0] conv_value, // analog core result
	output logic [3:0] offset_trim_value, // trim to analog core
	output logic conv_busy, // conversion running
	output logic [2:0] conv_chan, // channel being converted
	output logic converter_irq, // interrupt request line
	output logic dma_req, // dma request line
	output logic irq // summary interrupt, status and mask
);
	localparam logic [31:0] CONV_LAST = 32'(CONV_CYC - 1);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [3:0] trim;
		logic [7:0] irqen;
		logic [7:0] done;
		logic [7:0] ovr;
		logic [7:0][RES_W-1:0] res;
		logic [1:0] irqst;
		logic [1:0] irqmsk;
		adst_conv_t st;
		logic [31:0] cnt;
		logic [2:0] chan;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] bresp;
	} adst_top_st_t;
	adst_top_st_t s_q, s_d;
	logic trig_pulse;
	logic [31:0] status_word;
	logic conv_end;
	logic wr_fire;
	logic rd_fire;
	logic sw_start;
	logic [7:0] rd_clr;
	logic [1:0] ev;
	function automatic logic [31:0] strb_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction
	function automatic logic is_result(input logic [7:0] a);
		return (a >= `ADST_OFF_RESULT0) && (a < `ADST_OFF_RESULT0 + 8'h20);
	endfunction
	//==============================================================
	// trigger
	adst_edge u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.start_sel(s_q.ctrl[`ADST_CTRL_START_LSB +: 3]),
		.edge_pol(s_q.ctrl[`ADST_CTRL_EDGE]),
		.trig_pin(trig_pin),
		.trig_match(trig_match),
		.trig_pulse(trig_pulse)
	);
	//==============================================================
	// status and requests
	always_comb begin
		status_word = '0;
		status_word[7:0] = s_q.done;
		status_word[15:8] = s_q.ovr;
		status_word[`ADST_STAT_IRQ_BIT] = |(s_q.done & s_q.irqen);
	end
	// same line feeds both controllers
	assign converter_irq = status_word[`ADST_STAT_IRQ_BIT];
	assign dma_req = converter_irq;
	assign irq = |(s_q.irqst & s_q.irqmsk);
	assign offset_trim_value = s_q.trim;
	assign conv_busy = (s_q.st == ADST_CONV);
	assign conv_chan = s_q.chan;
	assign conv_end = (s_q.st == ADST_CONV) && (s_q.cnt == CONV_LAST);
	//==============================================================
	// axi handshakes
	// a frozen slave must not complete a handshake it cannot record
	assign s_axi_awready = ce && !s_q.aw_got && !s_q.bvalid;
	assign s_axi_wready = ce && !s_q.w_got && !s_q.bvalid;
	assign s_axi_arready = ce && !s_q.rvalid;
	assign s_axi_bvalid = ce && s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_rvalid = ce && s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	always_comb begin
		logic aw_ok;
		logic w_ok;
		logic [7:0] a;
		logic [31:0] wd;
		logic [3:0] ws;
		logic [2:0] ci;
		logic [31:0] nctrl;
		aw_ok = s_q.aw_got || (s_axi_awvalid && s_axi_awready);
		w_ok = s_q.w_got || (s_axi_wvalid && s_axi_wready);
		a = s_q.aw_got ? s_q.awaddr : s_axi_awaddr;
		wd = s_q.w_got ? s_q.wdata : s_axi_wdata;
		ws = s_q.w_got ? s_q.wstrb : s_axi_wstrb;
		ci = 3'(s_axi_araddr[4:2]);
		nctrl = s_q.ctrl;
		s_d = s_q;
		wr_fire = aw_ok && w_ok;
		sw_start = 1'b0;
		rd_clr = '0;
		ev = '0;
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = 2'b00;
			case ({a[7:2], 2'b00})
			`ADST_OFF_CTRL: begin
				nctrl = strb_merge(s_q.ctrl, wd, ws);
				s_d.ctrl = nctrl;
				sw_start = !nctrl[`ADST_CTRL_BURST]
					&& (nctrl[`ADST_CTRL_START_LSB +: 3] == 3'h1);
				// start field self-clears so a later write is a new request
				if (sw_start) begin
					s_d.ctrl[`ADST_CTRL_START_LSB +: 3] = 3'h0;
				end
			end
			`ADST_OFF_STATUS: ; // read only, writes dropped
			`ADST_OFF_TRIM: begin
				if (ws[0]) begin
					s_d.trim = wd[`ADST_TRIM_LSB +: 4];
				end
			end
			`ADST_OFF_IRQEN: begin
				if (ws[0]) begin
					s_d.irqen = wd[7:0];
				end
			end
			`ADST_OFF_IRQST: ;
			`ADST_OFF_IRQMSK: begin
				if (ws[0]) begin
					s_d.irqmsk = wd[1:0];
				end
			end
			default: begin
				if (!is_result({a[7:2], 2'b00})) begin
					s_d.bresp = 2'b10;
				end
			end
			endcase
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (rd_fire) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = 2'b00;
			s_d.rdata = '0;
			case ({s_axi_araddr[7:2], 2'b00})
			`ADST_OFF_CTRL: s_d.rdata = s_q.ctrl;
			`ADST_OFF_STATUS: s_d.rdata = status_word; // no clear
			`ADST_OFF_TRIM: s_d.rdata[`ADST_TRIM_LSB +: 4] = s_q.trim;
			`ADST_OFF_IRQEN: s_d.rdata[7:0] = s_q.irqen;
			`ADST_OFF_IRQST: s_d.rdata[1:0] = s_q.irqst;
			`ADST_OFF_IRQMSK: s_d.rdata[1:0] = s_q.irqmsk;
			default: begin
				if (is_result({s_axi_araddr[7:2], 2'b00})) begin
					s_d.rdata[`ADST_RES_LSB +: RES_W] = s_q.res[ci];
					s_d.rdata[`ADST_RES_OVR] = s_q.ovr[ci];
					s_d.rdata[`ADST_RES_DONE] = s_q.done[ci];
					rd_clr[ci] = 1'b1;
				end else begin
					s_d.rresp = 2'b10;
				end
			end
			endcase
		end
		s_d.done = s_q.done & ~rd_clr;
		s_d.ovr = s_q.ovr & ~rd_clr;
		// read of the event status clears it; a new event in that cycle wins
		if (rd_fire && ({s_axi_araddr[7:2], 2'b00} == `ADST_OFF_IRQST)) begin
			s_d.irqst = '0;
		end
		//==============================================================
		// conversion engine
		case (s_q.st)
		ADST_IDLE: begin
			s_d.cnt = '0;
			if (s_q.ctrl[`ADST_CTRL_BURST] && (s_q.ctrl[7:0] != 8'h00)) begin
				s_d.st = ADST_CONV;
			end else if (sw_start || (trig_pulse
				&& !s_q.ctrl[`ADST_CTRL_BURST])) begin
				s_d.st = ADST_CONV;
			end
		end
		ADST_CONV: begin
			// triggers here are not stored anywhere
			s_d.cnt = s_q.cnt + 32'h1;
			if (conv_end) begin
				s_d.st = ADST_IDLE;
				s_d.cnt = '0;
				s_d.res[s_q.chan] = conv_value;
				s_d.done[s_q.chan] = 1'b1;
				// a read clear in the same cycle keeps overrun from setting; done still sets
				if (s_q.ctrl[`ADST_CTRL_BURST] && s_q.done[s_q.chan]
					&& !rd_clr[s_q.chan]) begin
					s_d.ovr[s_q.chan] = 1'b1;
				end
				ev[0] = 1'b1;
				if (s_q.ctrl[`ADST_CTRL_BURST] && s_q.done[s_q.chan]
					&& !rd_clr[s_q.chan]) begin
					ev[1] = 1'b1;
				end
			end
		end
		default: s_d.st = ADST_IDLE;
		endcase
		// pick next enabled channel when idle
		// enables come from the write in flight, so a start that also
		// changes the enables converts a channel it has just enabled
		if (s_q.st == ADST_IDLE && s_d.st == ADST_CONV) begin
			s_d.chan = s_q.chan;
			for (int k = 7; k >= 0; k--) begin
				if (nctrl[3'(s_q.chan + 3'(k) + 3'h1)]) begin
					s_d.chan = 3'(s_q.chan + 3'(k) + 3'h1);
				end
			end
		end
		s_d.irqst = s_d.irqst | ev;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.ctrl <= `ADST_CTRL_RST;
			s_q.trim <= `ADST_TRIM_RST;
			s_q.irqen <= `ADST_IRQEN_RST;
			s_q.st <= ADST_IDLE;
		end else if (ce) begin
			s_q <= s_d;
		end
	end
	//==============================================================
	// checks
	a_status_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && $past(rd_fire && s_axi_araddr[7:2] == 6'h1 && ce)
		|-> s_axi_rdata[31:17] == 15'h0)
		else $error("status reserved bits not zero");
	a_irq_flag_or: assert property (@(posedge aclk) disable iff (!aresetn)
		converter_irq == |(s_q.done & s_q.irqen))
		else $error("interrupt flag wrong");
	a_dma_same: assert property (@(posedge aclk) disable iff (!aresetn)
		dma_req == converter_irq)
		else $error("dma request differs from interrupt");
	a_conv_run_full: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(conv_busy) |-> $past(conv_end && ce))
		else $error("conversion aborted early");
	a_done_on_end: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && conv_end |=> s_q.done[$past(s_q.chan)])
		else $error("done not set at conversion end");
	a_busy_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && conv_busy && !conv_end |=> conv_busy
		&& conv_chan == $past(conv_chan))
		else $error("start accepted while busy");
	a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && |rd_clr && !conv_end |=> (s_q.done & $past(rd_clr)) == 8'h0)
		else $error("result read did not clear done");
	a_trim_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !wr_fire |=> offset_trim_value == $past(offset_trim_value))
		else $error("trim changed without write");
	a_stat_nowr: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !conv_end && rd_clr == 8'h0 |=> s_q.done == $past(s_q.done))
		else $error("done changed without cause");
	c_hw_trig: cover property (@(posedge aclk) trig_pulse && !conv_busy);
	c_overrun: cover property (@(posedge aclk) |s_q.ovr);
	c_irq: cover property (@(posedge aclk) irq);
endmodule
`default_nettype wire
